// >>> pwr_clk_pkg.sv
/*
 power-mode and bus-clock controller package: register indices, field positions,
 reset values, enumerations and timing constants.
 assumes a single 250 MHz system clock domain.
*/
package pwr_clk_pkg;
   // register indices on the plain register port
   localparam logic [3:0] ADDR_PROTECT = 4'ha;
   localparam logic [3:0] ADDR_CLK_CTRL0 = 4'h6;
   localparam logic [3:0] ADDR_CLK_CTRL1 = 4'h7;
   localparam logic [3:0] ADDR_WAKE_CFG = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_CPU_STATE = 4'h2;

   // clock control 0 fields
   localparam int B_WAIT_GATE = 2;
   localparam int B_SUB_PORT_EN = 4;
   localparam int B_MAIN_STOP = 5;
   localparam int B_FIX_DIV8 = 6;
   localparam int B_SRC_SEL = 7;
   // clock control 1 fields
   localparam int B_ALL_STOP = 0;
   localparam int B_MAIN_DRIVE = 5;
   localparam int B_DIV_LO = 6;
   localparam int B_DIV_HI = 7;
   // clock control 0 bit 3 holds the sub-oscillator drive strength
   localparam int B_SUB_DRIVE = 3;
   localparam int B_PROTECT_CLK = 0;

   localparam logic [7:0] CTRL0_RESET = 8'h48;
   localparam logic [7:0] CTRL1_RESET = 8'h20;

   // wake configuration fields
   localparam int B_SER_EXT_CLK = 0;
   localparam int B_TMR_EVENT = 1;
   localparam int B_TMR_SUB_CLOCK_DIV_THIRTY_TWO = 2;
   localparam int B_ADC_ONESHOT = 3;

   localparam int NUM_IRQ = 8;
   localparam int LVL_W = 3;

   // oscillation start-up interval before the clock is given back
   localparam int OSC_START_NS = 2000;
   localparam int CLK_PERIOD_NS = 4;
   localparam int OSC_START_CYC = (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 10;
   localparam int DIV_W = 4;

   localparam logic [1:0] DIV_SEL_2 = 2'h0;
   localparam logic [1:0] DIV_SEL_4 = 2'h1;
   localparam logic [1:0] DIV_SEL_16 = 2'h2;
   localparam logic [1:0] DIV_SEL_8 = 2'h3;

   // interrupt kinds and their wake qualification
   typedef enum logic [1:0] {IRQ_PIN, IRQ_SERIAL, IRQ_TIMER, IRQ_ADC} irq_kind_t;
   localparam logic [2*NUM_IRQ-1:0] IRQ_KINDS = 16'h1b90;

   typedef enum logic [2:0] {
      PM_RUN, PM_WAIT, PM_STOP, PM_OSC_START, PM_ISEQ
   } pm_state_t;

   typedef enum logic [2:0] {
      SQ_READ_VEC, SQ_SAVE_FLAG, SQ_PUSH_FLAG, SQ_PUSH_PC, SQ_SET_IPL, SQ_FETCH
   } seq_state_t;

   localparam int B_FLG_U = 7;
   localparam int B_FLG_I = 6;
   localparam int B_FLG_D = 2;
   localparam logic [5:0] SW_INT_LO = 6'h20;
endpackage

// >>> pwr_clk_ctrl.sv
/*
 power-mode and bus-clock controller: clock selection and division, run / wait /
 stop modes, wake qualification, and the cpu interrupt sequence after wake-up.
 assumes all inputs synchronous to mclk and the register port master of the house.
*/
module pwr_clk_ctrl
   import pwr_clk_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire logic main_osc_input_pin,
   input wire logic secondary_osc_clock,
   output logic main_osc_output_pin,
   output logic main_feedback_connect,
   output logic sub_osc_output_pin,
   output logic sub_osc_pins_oe,
   output logic main_osc_enable,
   output logic sub_osc_enable,
   output logic main_drive_high,
   output logic sub_drive_high,
   output logic bus_clock,
   output logic cpu_clock_enable,
   output logic periph_clock_enable,
   output logic sub_periph_clock_enable,
   input wire logic wait_request,
   input wire logic [NUM_IRQ-1:0] irq_request,
   input wire logic [NUM_IRQ*LVL_W-1:0] irq_level,
   input wire logic global_int_enable,
   input wire logic [LVL_W-1:0] processor_priority_level,
   input wire logic [7:0] flag_word,
   input wire logic [5:0] int_number,
   input wire logic soft_int,
   output logic [NUM_IRQ-1:0] irq_clear,
   output logic seq_active,
   output logic [7:0] flag_temp,
   output logic [7:0] flag_new,
   output logic flag_load,
   output logic push_flags,
   output logic push_pc,
   output logic vector_read,
   output logic [LVL_W-1:0] new_ipl,
   output logic ipl_load,
   output logic handler_fetch
);
   logic [7:0] ctrl0_q;
   logic [7:0] ctrl1_q;
   logic [3:0] wake_cfg_q;
   logic protect_q;
   pm_state_t pm_q;
   seq_state_t sq_q;
   logic [CNT_W-1:0] osc_cnt_q;
   logic [DIV_W-1:0] div_cnt_q;
   logic bus_clock_q;
   logic [7:0] flag_temp_q;
   logic [$clog2(NUM_IRQ)-1:0] win_q;
   logic [LVL_W-1:0] win_lvl_q;
   logic [NUM_IRQ-1:0] accept;
   logic [NUM_IRQ-1:0] wake_ok;
   logic any_accept;
   logic [$clog2(NUM_IRQ)-1:0] win_idx;
   logic [LVL_W-1:0] win_lvl;
   logic gated;
   logic [DIV_W-1:0] half_div;
   logic src_sub;
   logic prot_wr;

   assign src_sub = ctrl0_q[B_SRC_SEL];
   assign gated = ctrl0_q[B_WAIT_GATE];
   assign prot_wr = protect_q & reg_write;

   // accept condition and which interrupt kinds may wake the current mode
   always_comb begin
      win_idx = '0;
      win_lvl = '0;
      any_accept = 1'b0;
      for (int i = 0; i < NUM_IRQ; i++) begin
         accept[i] = global_int_enable & irq_request[i] &
            (irq_level[i*LVL_W +: LVL_W] > processor_priority_level);
         unique case (irq_kind_t'(IRQ_KINDS[2*i +: 2]))
            IRQ_PIN: wake_ok[i] = 1'b1;
            IRQ_SERIAL: wake_ok[i] = (pm_q == PM_WAIT && !gated) || wake_cfg_q[B_SER_EXT_CLK];
            IRQ_TIMER: wake_ok[i] = (pm_q == PM_WAIT && !gated) || wake_cfg_q[B_TMR_EVENT] ||
               (pm_q == PM_WAIT && wake_cfg_q[B_TMR_SUB_CLOCK_DIV_THIRTY_TWO]);
            IRQ_ADC: wake_ok[i] = pm_q == PM_WAIT && !gated && wake_cfg_q[B_ADC_ONESHOT];
         endcase
         if (pm_q == PM_RUN)
            wake_ok[i] = 1'b1;
         if (accept[i] && wake_ok[i] && (!any_accept || irq_level[i*LVL_W +: LVL_W] > win_lvl)) begin
            any_accept = 1'b1;
            win_idx = i[$clog2(NUM_IRQ)-1:0];
            win_lvl = irq_level[i*LVL_W +: LVL_W];
         end
      end
   end

   // protect bit gates writes to both clock control registers
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         protect_q <= 1'b0;
      else if (reg_write && reg_addr == ADDR_PROTECT)
         protect_q <= reg_wdata[B_PROTECT_CLK];
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl0_q <= CTRL0_RESET;
      end else if (pm_q == PM_RUN && prot_wr && reg_addr == ADDR_CLK_CTRL0 &&
         !reg_wdata[B_MAIN_STOP] && 1'b0) begin
         ctrl0_q <= reg_wdata;
      end else if (pm_q == PM_RUN && prot_wr && reg_addr == ADDR_CLK_CTRL0) begin
         ctrl0_q <= reg_wdata;
      end else if (pm_q == PM_RUN && prot_wr && reg_addr == ADDR_CLK_CTRL1 &&
         reg_wdata[B_ALL_STOP] && !src_sub) begin
         ctrl0_q[B_FIX_DIV8] <= 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         ctrl1_q <= CTRL1_RESET;
      else if (pm_q == PM_RUN && prot_wr && reg_addr == ADDR_CLK_CTRL1)
         ctrl1_q <= reg_wdata;
      else if (pm_q == PM_STOP && any_accept)
         ctrl1_q[B_ALL_STOP] <= 1'b0;
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         wake_cfg_q <= '0;
      else if (reg_write && reg_addr == ADDR_WAKE_CFG)
         wake_cfg_q <= reg_wdata[3:0];
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         reg_rdata <= '0;
      else if (reg_read) begin
         unique case (reg_addr)
            ADDR_PROTECT: reg_rdata <= {7'h00, protect_q};
            ADDR_CLK_CTRL0: reg_rdata <= ctrl0_q;
            ADDR_CLK_CTRL1: reg_rdata <= ctrl1_q;
            ADDR_WAKE_CFG: reg_rdata <= {4'h0, wake_cfg_q};
            ADDR_STATUS: reg_rdata <= {5'h00, pm_q};
            ADDR_CPU_STATE: reg_rdata <= {5'h00, sq_q};
            default: reg_rdata <= '0;
         endcase
      end else
         reg_rdata <= '0;
   end

   // power mode sequencing
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pm_q <= PM_RUN;
         osc_cnt_q <= '0;
      end else begin
         unique case (pm_q)
            PM_RUN: begin
               if (prot_wr && reg_addr == ADDR_CLK_CTRL1 && reg_wdata[B_ALL_STOP])
                  pm_q <= PM_STOP;
               else if (wait_request)
                  pm_q <= PM_WAIT;
               else if (any_accept)
                  pm_q <= PM_ISEQ;
            end
            PM_WAIT: if (any_accept) pm_q <= PM_ISEQ;
            PM_STOP: if (any_accept) begin
               pm_q <= PM_OSC_START;
               osc_cnt_q <= '0;
            end
            PM_OSC_START: begin
               osc_cnt_q <= osc_cnt_q + 1'b1;
               if (osc_cnt_q == CNT_W'(OSC_START_CYC - 1))
                  pm_q <= PM_ISEQ;
            end
            PM_ISEQ: if (sq_q == SQ_FETCH) pm_q <= PM_RUN;
         endcase
      end
   end

   // interrupt entry sequence, one step a cycle
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sq_q <= SQ_READ_VEC;
         win_q <= '0;
         win_lvl_q <= '0;
         flag_temp_q <= '0;
      end else if (pm_q != PM_ISEQ) begin
         sq_q <= SQ_READ_VEC;
         if (any_accept) begin
            win_q <= win_idx;
            win_lvl_q <= win_lvl;
         end
      end else begin
         unique case (sq_q)
            SQ_READ_VEC: sq_q <= SQ_SAVE_FLAG;
            SQ_SAVE_FLAG: begin
               flag_temp_q <= flag_word;
               sq_q <= SQ_PUSH_FLAG;
            end
            SQ_PUSH_FLAG: sq_q <= SQ_PUSH_PC;
            SQ_PUSH_PC: sq_q <= SQ_SET_IPL;
            SQ_SET_IPL: sq_q <= SQ_FETCH;
            SQ_FETCH: sq_q <= SQ_READ_VEC;
         endcase
      end
   end

   always_comb begin
      flag_new = flag_word;
      flag_new[B_FLG_I] = 1'b0;
      flag_new[B_FLG_D] = 1'b0;
      if (!(soft_int && int_number >= SW_INT_LO))
         flag_new[B_FLG_U] = 1'b0;
   end

   assign seq_active = pm_q == PM_ISEQ;
   assign vector_read = seq_active && sq_q == SQ_READ_VEC;
   assign irq_clear = vector_read ? (NUM_IRQ'(1) << win_q) : '0;
   assign flag_load = seq_active && sq_q == SQ_SAVE_FLAG;
   assign flag_temp = flag_temp_q;
   assign push_flags = seq_active && sq_q == SQ_PUSH_FLAG;
   assign push_pc = seq_active && sq_q == SQ_PUSH_PC;
   assign ipl_load = seq_active && sq_q == SQ_SET_IPL;
   assign new_ipl = win_lvl_q;
   assign handler_fetch = seq_active && sq_q == SQ_FETCH;

   // bus clock divider; selected ratio forced to eight by the fixed bit
   always_comb begin
      if (ctrl0_q[B_FIX_DIV8])
         half_div = DIV_W'(4);
      else begin
         unique case ({ctrl1_q[B_DIV_HI], ctrl1_q[B_DIV_LO]})
            DIV_SEL_2: half_div = DIV_W'(1);
            DIV_SEL_4: half_div = DIV_W'(2);
            DIV_SEL_8: half_div = DIV_W'(4);
            DIV_SEL_16: half_div = DIV_W'(8);
         endcase
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         div_cnt_q <= '0;
         bus_clock_q <= 1'b0;
      end else if (main_osc_input_pin) begin
         if (div_cnt_q >= half_div - 1'b1) begin
            div_cnt_q <= '0;
            bus_clock_q <= ~bus_clock_q;
         end else
            div_cnt_q <= div_cnt_q + 1'b1;
      end
   end

   // main clock pass-through branch is never taken; the main source always gives the divided clock
   always_comb begin
      if (src_sub)
         bus_clock = secondary_osc_clock;
      else if (!ctrl0_q[B_FIX_DIV8] && 1'b0)
         bus_clock = main_osc_input_pin;
      else
         bus_clock = bus_clock_q;
   end

   assign cpu_clock_enable = pm_q == PM_RUN || pm_q == PM_ISEQ;
   assign periph_clock_enable = (pm_q == PM_RUN || pm_q == PM_ISEQ ||
      (pm_q == PM_WAIT && !gated)) && !ctrl0_q[B_MAIN_STOP];
   assign sub_periph_clock_enable = pm_q != PM_STOP && pm_q != PM_OSC_START;
   assign main_osc_enable = !ctrl0_q[B_MAIN_STOP] && !ctrl1_q[B_ALL_STOP];
   assign sub_osc_enable = ctrl0_q[B_SUB_PORT_EN] && !ctrl1_q[B_ALL_STOP];
   assign main_osc_output_pin = !main_osc_enable ? 1'b1 : ~main_osc_input_pin;
   assign main_feedback_connect = !ctrl1_q[B_ALL_STOP];
   assign sub_osc_output_pin = ~secondary_osc_clock;
   assign sub_osc_pins_oe = sub_osc_enable;
   assign main_drive_high = ctrl1_q[B_MAIN_DRIVE];
   assign sub_drive_high = ctrl0_q[B_SUB_DRIVE];
endmodule

// >>> power_mode_clock_checker_sva.sv
/*
 port-level assertions for the power-mode and bus-clock controller.
 assumes it is bound to pwr_clk_ctrl and that everything runs on mclk.
*/
module power_mode_clock_checker
   import pwr_clk_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic global_int_enable,
   input wire logic [LVL_W-1:0] processor_priority_level,
   input wire logic [7:0] flag_word,
   input wire logic [5:0] int_number,
   input wire logic soft_int,
   input wire logic [NUM_IRQ-1:0] irq_clear,
   input wire logic seq_active,
   input wire logic [7:0] flag_new,
   input wire logic flag_load,
   input wire logic push_flags,
   input wire logic push_pc,
   input wire logic vector_read,
   input wire logic [LVL_W-1:0] new_ipl,
   input wire logic ipl_load,
   input wire logic handler_fetch,
   input wire logic main_osc_output_pin,
   input wire logic main_feedback_connect,
   input wire logic sub_osc_pins_oe,
   input wire logic main_osc_enable,
   input wire logic cpu_clock_enable
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   logic [CNT_W-1:0] warm_q;
   // cycles since the oscillator feedback came back, saturating so it never wraps
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) warm_q <= '1;
      else if (!main_feedback_connect) warm_q <= '0;
      else if (warm_q != '1) warm_q <= warm_q + 1'b1;
   end
   AST_CLEAR_ONEHOT: assert property (vector_read |-> $onehot(irq_clear))
      else $error("request clear is not one-hot at vector read");
   AST_FLAGS_BEFORE_PC: assert property (push_flags |-> ##[1:4] push_pc)
      else $error("program counter push did not follow flag push");
   AST_IPL_THEN_FETCH: assert property (ipl_load |-> ##[1:4] handler_fetch)
      else $error("handler fetch did not follow level load");
   AST_FLAG_CLEAR: assert property (flag_load |-> flag_new == ((flag_word & 8'h3b) |
      ((soft_int && int_number >= SW_INT_LO) ? (flag_word & 8'h80) : 8'h00)))
      else $error("new flag word wrong");
   AST_ALL_STOP_PINS: assert property (!main_feedback_connect |-> main_osc_output_pin && !sub_osc_pins_oe)
      else $error("oscillator pins wrong with all clocks stopped");
   AST_MAIN_STOP_HIGH: assert property (!main_osc_enable |-> main_osc_output_pin)
      else $error("main output pin not high with main oscillator stopped");
   AST_SEQ_CPU_CLOCK: assert property (seq_active |-> cpu_clock_enable)
      else $error("cpu clock off during interrupt sequence");
   AST_START_DELAY: assert property (vector_read |-> warm_q >= OSC_START_CYC - 2)
      else $error("sequence began before oscillator start-up");
   AST_ACCEPT_LEVEL: assert property (ipl_load |-> new_ipl > processor_priority_level)
      else $error("accepted level not above processor level");
   AST_ACCEPT_ENABLE: assert property ($rose(seq_active) |-> $past(global_int_enable))
      else $error("interrupt accepted with global enable low");
   cover property (vector_read);
   cover property ($fell(main_feedback_connect));
   cover property ($fell(cpu_clock_enable) && main_feedback_connect);
endmodule

// >>> cpu_side_model.sv
/*
 far-side model: interrupt request bits of the priority logic and the two oscillators.
 assumes the testbench pulses irq_set and the controller pulses irq_clear.
*/
module cpu_side_model
   import pwr_clk_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic main_osc_enable,
   input wire logic sub_osc_enable,
   input wire logic [NUM_IRQ-1:0] irq_clear,
   input wire logic [NUM_IRQ-1:0] irq_set,
   output logic [NUM_IRQ-1:0] irq_request,
   output logic main_osc_input_pin,
   output logic secondary_osc_clock
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] sub_div_q;
   // a request stays pending until the sequence clears the one it serviced
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) irq_request <= '0;
      else irq_request <= (irq_request | irq_set) & ~irq_clear;
   end
   // stopped oscillators stand still rather than toggle
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) main_osc_input_pin <= 1'b0;
      else if (main_osc_enable) main_osc_input_pin <= ~main_osc_input_pin;
   end
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) sub_div_q <= 2'h0;
      else if (sub_osc_enable) sub_div_q <= sub_div_q + 2'h1;
   end
   assign secondary_osc_clock = sub_div_q[1];
endmodule

// >>> power_mode_clock_controller_test.sv
/*
 testbench for the power-mode and bus-clock controller: register access, wait and stop
 entry, wake qualification and the interrupt sequence. assumes a 250 MHz mclk.
*/
module power_mode_clock_controller_test;
   import pwr_clk_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic wait_request = 1'b0;
   logic global_int_enable = 1'b1;
   logic [LVL_W-1:0] processor_priority_level = 3'h1;
   logic [NUM_IRQ*LVL_W-1:0] irq_level = '0;
   logic [7:0] flag_word = 8'hc5;
   logic [NUM_IRQ-1:0] irq_set = '0;
   logic [NUM_IRQ-1:0] irq_request, irq_clear;
   logic [7:0] reg_rdata, flag_temp, flag_new;
   logic [LVL_W-1:0] new_ipl;
   logic main_osc_input_pin, secondary_osc_clock, main_osc_output_pin, main_feedback_connect, sub_osc_pins_oe;
   logic main_osc_enable, sub_osc_enable, main_drive_high, sub_drive_high, cpu_clock_enable, periph_clock_enable;
   logic bus_clock;
   logic seq_active, flag_load, push_flags, push_pc, vector_read, ipl_load, handler_fetch;
   int n_fail = 0;
   int check_count = 0;
   int cycles = 0;
   int n_vec = 0;
   int waited = 0;
   always #2 mclk = ~mclk;
   pwr_clk_ctrl u_pwr_clk_ctrl (.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
      .main_osc_input_pin, .secondary_osc_clock, .main_osc_output_pin, .main_feedback_connect,
      .sub_osc_output_pin(), .sub_osc_pins_oe, .main_osc_enable, .sub_osc_enable, .main_drive_high,
      .sub_drive_high, .bus_clock, .cpu_clock_enable, .periph_clock_enable, .sub_periph_clock_enable(),
      .wait_request, .irq_request, .irq_level, .global_int_enable, .processor_priority_level, .flag_word,
      .int_number(6'h00), .soft_int(1'b0), .irq_clear, .seq_active, .flag_temp, .flag_new, .flag_load,
      .push_flags, .push_pc, .vector_read, .new_ipl, .ipl_load, .handler_fetch);
   cpu_side_model u_cpu_side_model (.mclk, .reset_n, .main_osc_enable, .sub_osc_enable, .irq_clear,
      .irq_set, .irq_request, .main_osc_input_pin, .secondary_osc_clock);
   task automatic summarize();
      if (n_fail == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
         n_fail++;
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge mclk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge mclk);
      reg_read <= 1'b0;
      #1 chk($sformatf("register %h", a), exp, reg_rdata);
   endtask
   task automatic raise(input int i, input logic [2:0] lvl, input logic req);
      @(posedge mclk);
      irq_level[i*3 +: 3] <= lvl;
      irq_set <= {7'h00, req} << i;
      @(posedge mclk);
      irq_set <= '0;
   endtask
   task automatic await(ref logic s, input int limit);
      waited = 0;
      do begin
         @(posedge mclk);
         #1 waited++;
      end while (s !== 1'b1 && waited < limit);
      // a strobe that never came must not let the following compares pass by chance
      chk("awaited strobe", 8'h01, {7'h00, s});
   endtask
   // follows one interrupt sequence from vector read to handler fetch
   task automatic serve(input int limit, input logic [2:0] lvl);
      int t;
      await(vector_read, limit);
      t = waited;
      chk("irq_clear", 8'h01, irq_clear);
      await(push_flags, 8);
      chk("flag_temp", flag_word, flag_temp);
      await(ipl_load, 8);
      chk("new_ipl", lvl, new_ipl);
      await(handler_fetch, 8);
      waited = t;
   endtask
   always @(negedge mclk) if (vector_read === 1'b1) n_vec++;
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 6000) begin
         n_fail++;
         summarize();
      end
   end
   initial begin
      repeat (8) @(posedge mclk);
      reset_n <= 1'b1;
      rd(ADDR_CLK_CTRL0, 8'h48);
      rd(ADDR_CLK_CTRL1, 8'h20);
      rd(4'hf, 8'h00);
      chk("main_drive_high", 8'h01, main_drive_high);
      wr(ADDR_CLK_CTRL1, 8'h00);
      rd(ADDR_CLK_CTRL1, 8'h20);
      wr(ADDR_PROTECT, 8'h01);
      wr(ADDR_CLK_CTRL1, 8'h40);
      wr(ADDR_CLK_CTRL0, 8'h00);
      rd(ADDR_CLK_CTRL1, 8'h40);
      chk("main_drive_high", 8'h00, main_drive_high);
      chk("sub_drive_high", 8'h00, sub_drive_high);
      @(posedge mclk);
      wait_request <= 1'b1;
      @(posedge mclk);
      wait_request <= 1'b0;
      repeat (2) @(posedge mclk);
      #1 chk("cpu_clock_enable", 8'h00, cpu_clock_enable);
      chk("main_osc_enable", 8'h01, main_osc_enable);
      raise(0, 3'h3, 1'b1);
      serve(8, 3'h3);
      rd(ADDR_CLK_CTRL0, 8'h00);
      rd(ADDR_CLK_CTRL1, 8'h40);
      wr(ADDR_WAKE_CFG, 8'h08);
      wr(ADDR_CLK_CTRL1, 8'h41);
      rd(ADDR_CLK_CTRL0, 8'h40);
      chk("main_feedback_connect", 8'h00, main_feedback_connect);
      chk("sub_osc_pins_oe", 8'h00, sub_osc_pins_oe);
      chk("cpu_clock_enable", 8'h00, cpu_clock_enable);
      chk("periph_clock_enable", 8'h00, periph_clock_enable);
      chk("main_osc_enable", 8'h00, main_osc_enable);
      // level equal to the processor level, and a converter request, must both leave stop alone
      raise(0, 3'h1, 1'b1);
      raise(4, 3'h5, 1'b1);
      repeat (700) @(posedge mclk);
      chk("sequence count", 8'h01, n_vec[7:0]);
      raise(4, 3'h0, 1'b0);
      raise(0, 3'h3, 1'b0);
      serve(700, 3'h3);
      chk("start-up wait", 8'h01, waited >= OSC_START_CYC - 2);
      rd(ADDR_CLK_CTRL1, 8'h40);
      wr(ADDR_CLK_CTRL0, 8'h10);
      wr(ADDR_CLK_CTRL0, 8'h90);
      #1 chk("bus_clock", {7'h00, secondary_osc_clock}, {7'h00, bus_clock});
      wr(ADDR_CLK_CTRL0, 8'hb0);
      #1 chk("main_osc_output_pin", 8'h01, main_osc_output_pin);
      chk("main_feedback_connect", 8'h01, main_feedback_connect);
      chk("main_osc_enable", 8'h00, main_osc_enable);
      wr(ADDR_CLK_CTRL1, 8'h41);
      raise(0, 3'h3, 1'b1);
      serve(700, 3'h3);
      rd(ADDR_CLK_CTRL0, 8'hb0);
      summarize();
   end
endmodule
bind pwr_clk_ctrl power_mode_clock_checker u_power_mode_clock_checker (.mclk, .reset_n, .global_int_enable,
   .processor_priority_level, .flag_word, .int_number, .soft_int, .irq_clear, .seq_active, .flag_new, .flag_load,
   .push_flags, .push_pc, .vector_read, .new_ipl, .ipl_load, .handler_fetch, .main_osc_output_pin,
   .main_feedback_connect, .sub_osc_pins_oe, .main_osc_enable, .cpu_clock_enable);
